//--- hw/hpu_device.sv
`timescale 1ns/1ps
module hpu_device
  import hpu_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // Host link
  hpu_if.dev_mp                        link,
  // Configuration
  input  wire hpu_mode_type            mode_sel,
  input  wire logic [`HPU_PAGE_W-1:0]  page_upper,
  output logic      [`HPU_WORD_W-1:0]  ctrl_value,
  // Internal memory access
  output logic                         mem_req,
  output logic                         mem_we,
  output logic      [`HPU_WORD_W-1:0]  mem_addr,
  output logic      [`HPU_WORD_W-1:0]  mem_wdata,
  output logic      [`HPU_BE_W-1:0]    mem_be,
  input  wire logic [`HPU_WORD_W-1:0]  mem_rdata,
  input  wire logic                    mem_ack
);
  localparam int SW = 2 + 2 + 1 + 1 + `HPU_BE_W + `HPU_PAGE_W + `HPU_WORD_W;

  typedef enum logic [1:0] {
    HPU_DS_IDLE   = 2'h0,
    HPU_DS_ACTIVE = 2'h1,
    HPU_DS_RD     = 2'h2,
    HPU_DS_WR     = 2'h3
  } hpu_dev_state_type;

  logic [SW-1:0]            raw_in, syn_in;
  logic                     strobe_s, cs_s, rw_s, hi_s;
  hpu_access_type           type_s;
  logic [1:0]               type_raw;
  logic [`HPU_BE_W-1:0]     be_s;
  logic [`HPU_PAGE_W-1:0]   addr_s;
  logic [`HPU_WORD_W-1:0]   data_s;
  logic                     half_mode, busy;

  hpu_dev_state_type        state_reg, state_next;
  logic                     taken_reg, taken_next;
  hpu_access_type           type_reg, type_next;
  logic                     rw_reg, rw_next;
  logic                     hi_reg, hi_next;
  logic [`HPU_BE_W-1:0]     be_reg, be_next;
  logic [`HPU_BE_W-1:0]     wbe_reg, wbe_next;
  logic [`HPU_WORD_W-1:0]   ctrl_reg, ctrl_next;
  logic [`HPU_WORD_W-1:0]   addr_reg, addr_next;
  logic [`HPU_WORD_W-1:0]   maddr_reg, maddr_next;
  logic [`HPU_WORD_W-1:0]   rbuf_reg, rbuf_next;
  logic [`HPU_WORD_W-1:0]   wbuf_reg, wbuf_next;
  logic [`HPU_WORD_W-1:0]   dout_reg, dout_next;
  logic                     doe_reg, doe_next;

  // Access types that the current mode accepts
  function automatic logic type_ok(input hpu_mode_type m, input hpu_access_type t);
    return (m != HPU_MODE_NONMUX) || (t == HPU_ACC_CTRL) || (t == HPU_ACC_DATA_FIX); // R8
  endfunction : type_ok

  function automatic logic is_data(input hpu_access_type t);
    return (t == HPU_ACC_DATA_INC) || (t == HPU_ACC_DATA_FIX);
  endfunction : is_data

  ////////////////////////////////////////////////////////////////////////////
  // Pin capture

  // Strobe combined before syncing, so one filter times every access
  assign raw_in = {~link.host_chip_select_n &
                   (link.host_data_strobes[1] ^ link.host_data_strobes[2]), // R2
                   ~link.host_chip_select_n, link.host_access_type_select,
                   link.host_read_not_write, link.halfword_identifier,
                   link.host_byte_enables, link.host_address, link.host_data_bus};

  hpu_sync #(.W(SW), .INIT('0)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (raw_in),
    .q      (syn_in)
  );

  // Whole bundle shares one filter to keep fields aligned with the strobe
  always_comb begin
    {strobe_s, cs_s, type_raw, rw_s, hi_s, be_s, addr_s, data_s} = syn_in;
    type_s = hpu_access_type'(type_raw);
  end

  assign half_mode = (mode_sel == HPU_MODE_MUX_HALF); // R1

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencing

  // Next state of the access engine
  always_comb begin
    state_next = state_reg;
    taken_next = taken_reg;
    type_next  = type_reg;
    rw_next    = rw_reg;
    hi_next    = hi_reg;
    be_next    = be_reg;
    wbe_next   = wbe_reg;
    ctrl_next  = ctrl_reg;
    addr_next  = addr_reg;
    maddr_next = maddr_reg;
    rbuf_next  = rbuf_reg;
    wbuf_next  = wbuf_reg;
    dout_next  = dout_reg;
    doe_next   = doe_reg;
    if (!strobe_s) taken_next = 1'b0;
    unique case (state_reg)
      HPU_DS_IDLE: begin
        doe_next = 1'b0;
        if (strobe_s && !taken_reg) begin
          // Address and control taken at the strobe start
          taken_next = 1'b1; // R3
          type_next  = type_s; // R6
          rw_next    = rw_s;
          hi_next    = half_mode & hi_s; // R12
          be_next    = be_s;
          // Upper half of the address fixed inside in non-multiplexed mode
          maddr_next = (mode_sel == HPU_MODE_NONMUX) ?
                       {page_upper, addr_s} : addr_reg; // R15
          state_next = HPU_DS_ACTIVE;
          if (rw_s) begin
            if (type_ok(mode_sel, type_s) && is_data(type_s) && !(half_mode & hi_s)) begin
              state_next = HPU_DS_RD; // R13
            end else begin
              doe_next = 1'b1;
              unique case (type_s)
                HPU_ACC_CTRL: dout_next = hpu_pick_half(ctrl_reg, half_mode, hi_s);
                HPU_ACC_ADDR: dout_next = type_ok(mode_sel, type_s) ?
                              hpu_pick_half(addr_reg, half_mode, hi_s) : `HPU_ZERO_WORD;
                default:      dout_next = type_ok(mode_sel, type_s) ?
                              hpu_pick_half(rbuf_reg, half_mode, hi_s) : `HPU_ZERO_WORD;
              endcase
            end
          end
        end
      end
      HPU_DS_RD: begin
        if (mem_ack) begin
          rbuf_next  = mem_rdata;
          dout_next  = hpu_pick_half(mem_rdata, half_mode, 1'b0); // R11 R14
          doe_next   = 1'b1;
          state_next = HPU_DS_ACTIVE;
        end
      end
      HPU_DS_ACTIVE: begin
        if (!strobe_s) begin
          doe_next   = 1'b0;
          state_next = HPU_DS_IDLE;
          if (!rw_reg && type_ok(mode_sel, type_reg)) begin
            // Write data taken at the strobe end
            unique case (type_reg)
              HPU_ACC_CTRL: ctrl_next = hpu_put_half(ctrl_reg, data_s, half_mode, hi_reg); // R4 R6
              HPU_ACC_ADDR: addr_next = hpu_put_half(addr_reg, data_s, half_mode, hi_reg); // R6
              default: begin
                wbuf_next = hpu_put_half(wbuf_reg, data_s, half_mode, hi_reg); // R4 R11
                if (!half_mode) wbe_next = be_reg;
                else if (hi_reg) wbe_next = {be_reg[`HPU_BE_LO_MSB:0],
                                             wbe_reg[`HPU_BE_LO_MSB:0]};
                else wbe_next = {wbe_reg[`HPU_BE_W-1:`HPU_BE_HI_LSB],
                                 be_reg[`HPU_BE_LO_MSB:0]};
                if (!half_mode || hi_reg) state_next = HPU_DS_WR;
              end
            endcase
          end else if (rw_reg && type_reg == HPU_ACC_DATA_INC && type_ok(mode_sel, type_reg)
                       && (!half_mode || hi_reg)) begin
            addr_next = addr_reg + `HPU_ADDR_STEP; // R7 R16
          end
        end
      end
      HPU_DS_WR: begin
        // Posted write; the next access waits on ready until it lands
        if (mem_ack) begin
          if (type_reg == HPU_ACC_DATA_INC) addr_next = addr_reg + `HPU_ADDR_STEP; // R7 R16
          state_next = HPU_DS_IDLE;
        end
      end
    endcase
  end

  // Access engine registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= HPU_DS_IDLE;
      taken_reg <= 1'b0;
      type_reg  <= HPU_ACC_CTRL;
      rw_reg    <= 1'b0;
      hi_reg    <= 1'b0;
      be_reg    <= '0;
      wbe_reg   <= '0;
      ctrl_reg  <= `HPU_ZERO_WORD;
      addr_reg  <= `HPU_ZERO_WORD;
      maddr_reg <= `HPU_ZERO_WORD;
      rbuf_reg  <= `HPU_ZERO_WORD;
      wbuf_reg  <= `HPU_ZERO_WORD;
      dout_reg  <= `HPU_ZERO_WORD;
      doe_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      taken_reg <= taken_next;
      type_reg  <= type_next;
      rw_reg    <= rw_next;
      hi_reg    <= hi_next;
      be_reg    <= be_next;
      wbe_reg   <= wbe_next;
      ctrl_reg  <= ctrl_next;
      addr_reg  <= addr_next;
      maddr_reg <= maddr_next;
      rbuf_reg  <= rbuf_next;
      wbuf_reg  <= wbuf_next;
      dout_reg  <= dout_next;
      doe_reg   <= doe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Busy also covers a strobe not yet taken, so ready falls without a gap
  assign busy = (state_reg == HPU_DS_RD) || (state_reg == HPU_DS_WR) ||
                ((state_reg == HPU_DS_IDLE) && strobe_s && !taken_reg); // R13
  // Raw select pin gates ready, so a deselected port never holds it low
  assign link.host_ready_out   = ~(~link.host_chip_select_n & cs_s & busy); // R5
  assign link.host_data_dev    = dout_reg;
  assign link.host_data_dev_oe = doe_reg;

  // Memory side
  assign mem_req    = (state_reg == HPU_DS_RD) || (state_reg == HPU_DS_WR);
  assign mem_we     = (state_reg == HPU_DS_WR);
  assign mem_addr   = maddr_reg;
  assign mem_wdata  = wbuf_reg;
  assign mem_be     = wbe_reg;
  assign ctrl_value = ctrl_reg;
endmodule : hpu_device

//--- include/hpu_map.svh
// Overview of operation
// R1 - Three modes: half-word, fullword, non-multiplexed fullword
// R2 - Chip select and strobes merge into one strobe
// R3 - Address and control latched at strobe start
// R4 - Write data latched at strobe end
// R5 - Ready drops only while chip selected
// R6 - Code 00 control, code 10 address register
// R7 - Code 01 data with increment, 11 without
// R8 - Non-multiplexed mode: only codes 00 and 11
// R9 - Increment runs start and end word-aligned
// R10 - All byte enables set during increment runs
// R11 - Half-word mode: two 16-bit accesses per word
// R12 - Half identifier low first, high second
// R13 - Ready held low until internal access completes; writes are posted, so the next access waits on ready instead
// R14 - Fullword mode uses all 32 lines
// R15 - Non-multiplexed: 64K page, upper bits internal
// R16 - Increment advances address by four bytes
`ifndef HPU_MAP_SVH
`define HPU_MAP_SVH

// Field layout of the host data lines
`define HPU_WORD_W    32
`define HPU_HALF_W    16
`define HPU_LO_MSB    15
`define HPU_HI_LSB    16
`define HPU_HI_MSB    31
`define HPU_PAGE_W    16
`define HPU_BE_W      4
`define HPU_BE_LO_MSB 1
`define HPU_BE_HI_LSB 2

// Reset and idle values, and the address increment step
`define HPU_ZERO_WORD 32'h0000_0000
`define HPU_ZERO_HALF 16'h0000
`define HPU_IDLE_BUS  32'hFFFF_FFFF
`define HPU_ADDR_STEP 32'h0000_0004

// Host end timing, in ns, and cycles at the system clock
`define HPU_CLK_NS    5
`define HPU_SETUP_NS  10
`define HPU_STROBE_NS 45
`define HPU_HOLD_NS   30
`define HPU_CYC(ns)   (((ns) + `HPU_CLK_NS - 1) / `HPU_CLK_NS)

`endif

//--- include/hpu_pkg.sv
package hpu_pkg;
  `include "hpu_map.svh"

  // Access type driven on the two select pins
  typedef enum logic [1:0] {
    HPU_ACC_CTRL     = 2'h0,
    HPU_ACC_DATA_INC = 2'h1,
    HPU_ACC_ADDR     = 2'h2,
    HPU_ACC_DATA_FIX = 2'h3
  } hpu_access_type;

  // Port operating mode
  typedef enum logic [1:0] {
    HPU_MODE_MUX_HALF = 2'h0,
    HPU_MODE_MUX_FULL = 2'h1,
    HPU_MODE_NONMUX   = 2'h2
  } hpu_mode_type;

  // Place a 16-bit half into a word, or pass a full word through
  function automatic logic [`HPU_WORD_W-1:0] hpu_put_half(
    input logic [`HPU_WORD_W-1:0] word,
    input logic [`HPU_WORD_W-1:0] data,
    input logic                   half_mode,
    input logic                   upper);
    logic [`HPU_WORD_W-1:0] res;
    res = data;
    if (half_mode) begin
      res = word;
      if (upper) res[`HPU_HI_MSB:`HPU_HI_LSB] = data[`HPU_LO_MSB:0];
      else res[`HPU_LO_MSB:0] = data[`HPU_LO_MSB:0];
    end
    return res;
  endfunction : hpu_put_half

  // Select the half that travels on the lower lines
  function automatic logic [`HPU_WORD_W-1:0] hpu_pick_half(
    input logic [`HPU_WORD_W-1:0] word,
    input logic                   half_mode,
    input logic                   upper);
    logic [`HPU_WORD_W-1:0] res;
    res = word;
    if (half_mode) begin
      if (upper) res = {`HPU_ZERO_HALF, word[`HPU_HI_MSB:`HPU_HI_LSB]};
      else res = {`HPU_ZERO_HALF, word[`HPU_LO_MSB:0]};
    end
    return res;
  endfunction : hpu_pick_half
endpackage : hpu_pkg

//--- include/hpu_if.sv
`timescale 1ns/1ps
interface hpu_if;
  logic                     host_chip_select_n;
  logic [2:1]               host_data_strobes;
  logic [1:0]               host_access_type_select;
  logic                     host_read_not_write;
  logic                     halfword_identifier;
  logic [3:0]               host_byte_enables;
  logic [15:0]              host_address;
  logic [31:0]              host_data_host;
  logic                     host_data_host_oe;
  logic [31:0]              host_data_dev;
  logic                     host_data_dev_oe;
  logic [31:0]              host_data_bus;
  logic                     host_ready_out;

  // Shared data lines resolved from the enables, pulled high when idle
  assign host_data_bus = host_data_dev_oe ? host_data_dev :
                         host_data_host_oe ? host_data_host : 32'hFFFF_FFFF;

  modport dev_mp (
    input  host_chip_select_n, host_data_strobes, host_access_type_select,
    input  host_read_not_write, halfword_identifier, host_byte_enables,
    input  host_address, host_data_bus,
    output host_data_dev, host_data_dev_oe, host_ready_out
  );
  modport host_mp (
    output host_chip_select_n, host_data_strobes, host_access_type_select,
    output host_read_not_write, halfword_identifier, host_byte_enables,
    output host_address, host_data_host, host_data_host_oe,
    input  host_data_bus, host_ready_out
  );
endinterface : hpu_if

//--- hw/hpu_sync.sv
`timescale 1ns/1ps
module hpu_sync #(
  parameter int              W    = 1,
  parameter logic [W-1:0]    INIT = '0
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // Asynchronous in, filtered out
  input  wire logic [W-1:0]  d,
  output logic      [W-1:0]  q
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
  logic [W-1:0] q_next;

  // A change counts only once stages two and three agree
  always_comb begin
    q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
  end

  // First stage feeds only the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q_reg  <= INIT;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q = q_reg;
endmodule : hpu_sync

//--- hw/hpu_host.sv
`timescale 1ns/1ps
module hpu_host
  import hpu_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // Host link
  hpu_if.host_mp                       link,
  // Configuration
  input  wire hpu_mode_type            mode_sel,
  // Command
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire hpu_access_type          cmd_type,
  input  wire logic                    cmd_read,
  input  wire logic [`HPU_PAGE_W-1:0]  cmd_addr,
  input  wire logic [`HPU_WORD_W-1:0]  cmd_wdata,
  input  wire logic [`HPU_BE_W-1:0]    cmd_be,
  // Response
  output logic                         rsp_valid,
  output logic      [`HPU_WORD_W-1:0]  rsp_rdata
);
  localparam logic [7:0] SETUP_CYC  = 8'(`HPU_CYC(`HPU_SETUP_NS));
  localparam logic [7:0] STROBE_CYC = 8'(`HPU_CYC(`HPU_STROBE_NS));
  localparam logic [7:0] HOLD_CYC   = 8'(`HPU_CYC(`HPU_HOLD_NS));

  typedef enum logic [1:0] {
    HPU_HS_IDLE   = 2'h0,
    HPU_HS_SETUP  = 2'h1,
    HPU_HS_STROBE = 2'h2,
    HPU_HS_HOLD   = 2'h3
  } hpu_host_state_type;

  logic [`HPU_WORD_W:0]     syn_in;
  logic                     ready_s, half_mode;
  logic [`HPU_WORD_W-1:0]   data_s;

  hpu_host_state_type       state_reg, state_next;
  logic [7:0]               cnt_reg, cnt_next;
  logic                     cs_reg, cs_next;
  logic                     stb_reg, stb_next;
  hpu_access_type           type_reg, type_next;
  logic                     rd_reg, rd_next;
  logic                     hi_reg, hi_next;
  logic [`HPU_BE_W-1:0]     be_reg, be_next;
  logic [`HPU_PAGE_W-1:0]   addr_reg, addr_next;
  logic [`HPU_WORD_W-1:0]   wdata_reg, wdata_next;
  logic [`HPU_WORD_W-1:0]   hd_reg, hd_next;
  logic                     hoe_reg, hoe_next;
  logic [`HPU_WORD_W-1:0]   rdata_reg, rdata_next;
  logic                     rsp_reg, rsp_next;

  ////////////////////////////////////////////////////////////////////////////
  // Pin capture

  hpu_sync #(.W(`HPU_WORD_W + 1), .INIT({1'b1, `HPU_IDLE_BUS})) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({link.host_ready_out, link.host_data_bus}),
    .q      (syn_in)
  );

  assign {ready_s, data_s} = syn_in;
  assign half_mode = (mode_sel == HPU_MODE_MUX_HALF);

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencing

  // Next state; minimum strobe covers the device's filter delay
  always_comb begin
    state_next = state_reg;
    cnt_next   = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : cnt_reg;
    cs_next    = cs_reg;
    stb_next   = stb_reg;
    type_next  = type_reg;
    rd_next    = rd_reg;
    hi_next    = hi_reg;
    be_next    = be_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    hd_next    = hd_reg;
    hoe_next   = hoe_reg;
    rdata_next = rdata_reg;
    rsp_next   = 1'b0;
    unique case (state_reg)
      HPU_HS_IDLE: begin
        if (cmd_valid) begin
          cs_next    = 1'b1;
          type_next  = cmd_type; // R6
          rd_next    = cmd_read;
          hi_next    = 1'b0; // R12
          be_next    = cmd_be;
          addr_next  = cmd_addr;
          wdata_next = cmd_wdata;
          hd_next    = hpu_pick_half(cmd_wdata, half_mode, 1'b0); // R11
          hoe_next   = ~cmd_read;
          cnt_next   = SETUP_CYC;
          state_next = HPU_HS_SETUP;
        end
      end
      HPU_HS_SETUP: begin
        if (cnt_reg == 8'h00) begin
          stb_next   = 1'b1;
          cnt_next   = STROBE_CYC;
          state_next = HPU_HS_STROBE;
        end
      end
      HPU_HS_STROBE: begin
        // Stretched while the device holds ready low
        if (cnt_reg == 8'h00 && ready_s) begin
          if (rd_reg) rdata_next = hpu_put_half(rdata_reg, data_s, half_mode, hi_reg); // R12
          stb_next   = 1'b0;
          cnt_next   = HOLD_CYC;
          state_next = HPU_HS_HOLD;
        end
      end
      HPU_HS_HOLD: begin
        if (cnt_reg == 8'h00) begin
          if (half_mode && !hi_reg) begin
            hi_next    = 1'b1; // R11 R12
            hd_next    = hpu_pick_half(wdata_reg, half_mode, 1'b1);
            cnt_next   = SETUP_CYC;
            state_next = HPU_HS_SETUP;
          end else begin
            cs_next    = 1'b0;
            hoe_next   = 1'b0;
            rsp_next   = 1'b1;
            state_next = HPU_HS_IDLE;
          end
        end
      end
    endcase
  end

  // Host registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= HPU_HS_IDLE;
      cnt_reg   <= 8'h00;
      cs_reg    <= 1'b0;
      stb_reg   <= 1'b0;
      type_reg  <= HPU_ACC_CTRL;
      rd_reg    <= 1'b0;
      hi_reg    <= 1'b0;
      be_reg    <= '0;
      addr_reg  <= `HPU_ZERO_HALF;
      wdata_reg <= `HPU_ZERO_WORD;
      hd_reg    <= `HPU_ZERO_WORD;
      hoe_reg   <= 1'b0;
      rdata_reg <= `HPU_ZERO_WORD;
      rsp_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cs_reg    <= cs_next;
      stb_reg   <= stb_next;
      type_reg  <= type_next;
      rd_reg    <= rd_next;
      hi_reg    <= hi_next;
      be_reg    <= be_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      hd_reg    <= hd_next;
      hoe_reg   <= hoe_next;
      rdata_reg <= rdata_next;
      rsp_reg   <= rsp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Second strobe held high so the first alone times the access
  assign link.host_chip_select_n      = ~cs_reg;
  assign link.host_data_strobes       = {1'b1, ~stb_reg};
  assign link.host_access_type_select = type_reg;
  assign link.host_read_not_write     = rd_reg;
  assign link.halfword_identifier     = hi_reg;
  assign link.host_byte_enables       = be_reg;
  assign link.host_address            = addr_reg;
  assign link.host_data_host          = hd_reg;
  assign link.host_data_host_oe       = hoe_reg;
  assign cmd_ready = (state_reg == HPU_HS_IDLE);
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;
endmodule : hpu_host

//--- verification/hpu_checker.sv
`timescale 1ns/1ps
module hpu_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Host link
  input wire logic        host_chip_select_n,
  input wire logic [2:1]  host_data_strobes,
  input wire logic [1:0]  host_access_type_select,
  input wire logic        host_read_not_write,
  input wire logic [3:0]  host_byte_enables,
  input wire logic [31:0] host_data_host,
  input wire logic        host_data_host_oe,
  input wire logic        host_data_dev_oe,
  input wire logic        host_ready_out
);
  // Merged strobe, formed from the same three pins as inside the device
  wire logic stb = !host_chip_select_n && (host_data_strobes[1] ^ host_data_strobes[2]);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////
  // Select kept low for the first four cycles of the hold phase
  sequence s_hold;
    !host_chip_select_n [*4];
  endsequence
  chk_ready_gated: assert property (!host_ready_out |-> !host_chip_select_n)
    else $error("ready low while deselected");
  chk_ctrl_held: assert property (stb && $past(stb) |-> $stable(host_access_type_select)
    && $stable(host_read_not_write) && $stable(host_byte_enables)) else $error("control moved");
  chk_wdata_held: assert property (stb && $past(stb) && !host_read_not_write
    |-> host_data_host_oe && $stable(host_data_host)) else $error("write data moved");
  chk_strobe_width: assert property ($rose(stb) |=> stb [*7])
    else $error("strobe too short");
  chk_end_on_ready: assert property ($fell(stb) |-> $past(host_ready_out))
    else $error("strobe ended while not ready");
  chk_read_answer: assert property ($rose(stb) && host_read_not_write
    |-> ##[1:100] host_data_dev_oe) else $error("no read data");
  chk_no_fight: assert property (!(host_data_dev_oe && host_data_host_oe))
    else $error("both ends drive data");
  chk_dev_release: assert property ($fell(stb) |-> ##[1:8] !host_data_dev_oe)
    else $error("device kept driving");
  chk_hold_phase: assert property ($fell(stb) |-> s_hold)
    else $error("select dropped in hold");
  chk_inc_bytes: assert property (stb && host_access_type_select == 2'h1
    |-> host_byte_enables == 4'hF) else $error("partial enables in run");
endmodule : hpu_checker

//--- verification/tb_universal_host_port_access.sv
`timescale 1ns/1ps
module tb_universal_host_port_access
  import hpu_pkg::*;
;
  logic clk, resetn, cmd_valid, cmd_read, mem_ack, mem_req, mem_we, cmd_ready, rsp_valid;
  logic [15:0] page, cmd_addr;
  logic [31:0] cmd_wdata, mem_rdata, mem_addr, mem_wdata, ctrl_value, rsp_rdata, q;
  logic [3:0] cmd_be, mem_be, wbe;
  hpu_mode_type mode;
  hpu_access_type cmd_type;
  logic [31:0] mem [logic [31:0]];
  int fail_count, n_checks, n_wr, lat, wc;
  hpu_if link ();
  hpu_device hpu_device_inst (.clk(clk), .resetn(resetn), .link(link), .mode_sel(mode),
    .page_upper(page), .ctrl_value(ctrl_value), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  hpu_host hpu_host_inst (.clk(clk), .resetn(resetn), .link(link), .mode_sel(mode),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_type(cmd_type), .cmd_read(cmd_read),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_be(cmd_be), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  hpu_checker hpu_checker_inst (.clk(clk), .resetn(resetn),
    .host_chip_select_n(link.host_chip_select_n), .host_data_strobes(link.host_data_strobes),
    .host_access_type_select(link.host_access_type_select),
    .host_read_not_write(link.host_read_not_write), .host_byte_enables(link.host_byte_enables),
    .host_data_host(link.host_data_host), .host_data_host_oe(link.host_data_host_oe),
    .host_data_dev_oe(link.host_data_dev_oe), .host_ready_out(link.host_ready_out));
  ////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Memory: acks after lat cycles, so slow answers stretch the host
  always @(posedge clk) begin
    #1;
    if (mem_ack) mem_ack = 1'b0;
    else if (mem_req === 1'b1 && wc < lat) wc++;
    else if (mem_req === 1'b1) begin
      wc = 0;
      mem_ack = 1'b1;
      mem_rdata = mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
      if (mem_we === 1'b1) begin
        mem[mem_addr] = mem_wdata;
        wbe = mem_be;
        n_wr++;
      end
    end
  end
  ////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic do_reset();
    resetn = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    resetn = 1'b1;
  endtask : do_reset
  // One host command; waits are bounded, a hang ends the run
  task automatic acc(input hpu_access_type t, input logic rd, input logic [15:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_type = t;
    cmd_read = rd;
    cmd_addr = a;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 400) begin
      fail_count++;
      $display("[FAIL] %0t no response", $time);
      give_verdict();
    end else q = rsp_rdata;
  endtask : acc
  task automatic t_ctrl();
    logic [31:0] w;
    for (int m = 0; m < 3; m++) begin
      mode = hpu_mode_type'(m);
      do_reset();
      w = 32'h5A00_C3E1 + 32'(m);
      acc(HPU_ACC_CTRL, 1'b0, 16'h0, w);
      chk(ctrl_value, w);
      acc(HPU_ACC_CTRL, 1'b1, 16'h0, 32'h0);
      chk(q, w);
    end
  endtask : t_ctrl
  // Posted writes land before the next access completes
  task automatic t_inc(input int m);
    logic [31:0] b;
    b = 32'hA5A5_0000 + 32'(m << 8);
    mode = hpu_mode_type'(m);
    lat = 3 - 3 * m;
    do_reset();
    acc(HPU_ACC_ADDR, 1'b0, 16'h0, 32'h0000_0100);
    for (int i = 0; i < 3; i++) acc(HPU_ACC_DATA_INC, 1'b0, 16'h0, b + 32'(i));
    acc(HPU_ACC_ADDR, 1'b0, 16'h0, 32'h0000_0100);
    for (int i = 0; i < 3; i++) chk(mem[32'h100 + 32'(4 * i)], b + 32'(i));
    chk(32'(wbe), 32'h0000_000F);
    acc(HPU_ACC_DATA_FIX, 1'b1, 16'h0, 32'h0);
    acc(HPU_ACC_DATA_FIX, 1'b1, 16'h0, 32'h0);
    chk(q, b);
    acc(HPU_ACC_DATA_INC, 1'b1, 16'h0, 32'h0);
    acc(HPU_ACC_DATA_INC, 1'b1, 16'h0, 32'h0);
    chk(q, b + 32'h1);
    acc(HPU_ACC_ADDR, 1'b1, 16'h0, 32'h0);
    chk(q, 32'h0000_0108);
  endtask : t_inc
  task automatic t_nmux();
    int n0;
    mode = HPU_MODE_NONMUX;
    page = 16'hABCD;
    do_reset();
    n0 = n_wr;
    acc(HPU_ACC_DATA_FIX, 1'b0, 16'h0010, 32'h1234_5678);
    acc(HPU_ACC_DATA_INC, 1'b0, 16'h0020, 32'h0BAD_0BAD);
    acc(HPU_ACC_DATA_FIX, 1'b1, 16'h0010, 32'h0);
    chk(q, 32'h1234_5678);
    chk(mem[32'hABCD_0010], 32'h1234_5678);
    acc(HPU_ACC_ADDR, 1'b1, 16'h0, 32'h0);
    chk(q, 32'h0);
    chk(32'(n_wr - n0), 32'h1);
  endtask : t_nmux
  ////////////////////////////////////////////////
  initial begin
    {resetn, cmd_valid, cmd_read, mem_ack, wc, n_wr, fail_count, n_checks, lat} = '0;
    {cmd_addr, cmd_wdata, mem_rdata, page} = '0;
    cmd_be = 4'hF;
    cmd_type = HPU_ACC_CTRL;
    mode = HPU_MODE_MUX_HALF;
    t_ctrl();
    t_inc(0);
    t_inc(1);
    t_nmux();
    give_verdict();
  end
endmodule : tb_universal_host_port_access
